// ### hw/irq_ctl_pkg.sv
// Package of constants and types for the DSP interrupt control block
//
// Overview of operation
// - Drive two interrupt lines to the core; servo-sector line has top priority.
// - Servo-sector line ORs search, acquisition, burst and setpoint-on when each enabled.
// - General line ORs all other enabled sources, never the four servo-sector ones.
// - Mask bit one lets its source reach a line; zero blocks it. Shock has no writable mask bit and always reaches the general line.
// - All sources are edge detected except shock, which acts on high level.
// - External source is raised by a falling edge on the external pin.
// - Mask and pending share fixed bit positions, all reset to zero.
// - In mask and pending, bits 15:12 and bit 6 ignore writes and read zero.
// - A source event sets its pending bit, which stays set until serviced.
// - Writing one to a pending bit clears it back to zero.
// - Pending bits set regardless of mask register or core masking.
// - Timer event fires on a tick at count zero, which reloads a periodic count and halts a single shot.
package irq_ctl_pkg;

    // -------------------------------------------------------------
    // Register map (word addresses on the plain register port)
    // -------------------------------------------------------------
    localparam int          ADDR_W                 = 8;
    localparam int          DATA_W                 = 16;
    localparam logic [7:0]  OFFS_ENABLE_MASK       = 8'h00;
    localparam logic [7:0]  OFFS_PENDING_FLAGS     = 8'h01;
    localparam logic [7:0]  OFFS_TIMER_CONTROL     = 8'h02;
    localparam logic [7:0]  OFFS_TIMER_INITIAL     = 8'h03;
    localparam logic [7:0]  OFFS_TIMER_CURRENT     = 8'h04;

    // -------------------------------------------------------------
    // Bit positions of sources in mask and pending
    // -------------------------------------------------------------
    localparam int          BIT_SERIAL_TX          = 0;
    localparam int          BIT_SERIAL_RX          = 1;
    localparam int          BIT_TIMER_ZERO         = 2;
    localparam int          BIT_COMMAND_DONE       = 3;
    localparam int          BIT_EXTERNAL           = 4;
    localparam int          BIT_SPINDLE            = 5;
    localparam int          BIT_SHOCK              = 7;
    localparam int          BIT_SEARCH_WINDOW      = 8;
    localparam int          BIT_ACQUISITION        = 9;
    localparam int          BIT_BURST              = 10;
    localparam int          BIT_SETPOINT_ON        = 11;

    localparam logic [15:0] WRITABLE_BITS          = 16'h0f3f;
    localparam logic [15:0] SERVO_SECTOR_BITS      = 16'h0f00;
    localparam logic [15:0] GENERAL_BITS           = 16'h003f;
    localparam logic [15:0] MASK_RESET             = 16'h0000;
    localparam logic [15:0] PENDING_RESET          = 16'h0000;

    // -------------------------------------------------------------
    // Timer control layout and reset values
    // -------------------------------------------------------------
    localparam int          TCTL_PERIODIC          = 8;
    localparam int          TCTL_RUN               = 7;
    localparam int          TCTL_PRESCALE_MSB      = 6;
    localparam logic [15:0] TCTL_WRITABLE          = 16'h01ff;
    localparam logic [15:0] TCTL_RESET             = 16'h0000;
    localparam logic [15:0] TINIT_RESET            = 16'h0000;
    localparam logic [15:0] TCOUNT_RESET           = 16'h0000;
    localparam logic        EXT_PIN_IDLE           = 1'b1;

    // -------------------------------------------------------------
    // Carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic setpoint_on_source;
        logic burst_seq;
        logic acq_seq;
        logic search_window_open;
        logic shock;
        logic spindle;
        logic command_done;
        logic serial_rx;
        logic serial_tx;
    } src_levels_t;

    typedef struct packed {
        logic       periodic;
        logic [6:0] prescale;
    } timer_cfg_t;

endpackage

// ### hw/event_timer.sv
// Down-counting timer that raises the timer-zero event
`timescale 1ns/1ns
module event_timer #(
    parameter int COUNT_W    = 16,
    parameter int PRESCALE_W = 7
) (
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_rst_b,
    input  wire irq_ctl_pkg::timer_cfg_t       i_cfg,
    input  wire logic                          i_run,
    input  wire logic                          i_start,
    input  wire logic [COUNT_W-1:0]            i_initial,
    output logic      [COUNT_W-1:0]            o_count,
    output logic                               o_zero_event,
    output logic                               o_stop
);
    generate
        if (COUNT_W != 16 || PRESCALE_W != 7) begin : g_bad_width
            $error("event_timer widths must match the register layout");
        end
    endgenerate

    logic [PRESCALE_W-1:0] div_reg;
    logic [PRESCALE_W-1:0] div_next;
    logic [COUNT_W-1:0]    count_next;
    // A single shot that just stopped must not tick again while its run bit
    // is being cleared, or the zero event would fire a second time.
    wire                   tick    = i_run && !o_stop && (div_reg == i_cfg.prescale);
    wire                   at_zero = (o_count == '0);

    // Zero reached: periodic reloads, single shot halts
    assign div_next   = (i_start || tick || !i_run) ? '0 : div_reg + 1'b1;
    assign count_next = i_start ? i_initial :
                        !tick   ? o_count :
                        at_zero ? (i_cfg.periodic ? i_initial : o_count) :
                        o_count - 1'b1;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_reg      <= '0;
            o_count      <= '0;
            o_zero_event <= 1'b0;
            o_stop       <= 1'b0;
        end else begin
            div_reg      <= div_next;
            o_count      <= count_next;
            o_zero_event <= tick && at_zero && !i_start;
            o_stop       <= tick && at_zero && !i_start && !i_cfg.periodic;
        end
    end
endmodule

// ### hw/dsp_interrupt_control_block.sv
// Interrupt control block: pending and mask registers, two lines to the DSP
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module dsp_interrupt_control_block (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rst_b,
    input  wire irq_ctl_pkg::reg_req_t      i_req,
    input  wire irq_ctl_pkg::src_levels_t   i_src,
    input  wire logic                       i_external_irq_pin,
    output logic [15:0]                     o_rd_data,
    output logic                            o_servo_sector_irq_line,
    output logic                            o_general_irq_line
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [15:0]                 enable_mask_reg;
    logic [15:0]                 enable_mask_next;
    logic [15:0]                 pending_flags_reg;
    logic [15:0]                 pending_flags_next;
    logic [15:0]                 timer_ctl_reg;
    logic [15:0]                 timer_ctl_next;
    logic [15:0]                 timer_init_reg;
    logic [15:0]                 timer_init_next;
    logic [15:0]                 rd_data_next;

    // ------------------------------------------------------------------
    // Edge detection state
    // ------------------------------------------------------------------
    irq_ctl_pkg::src_levels_t    src_prev_reg;
    logic                        ext_pin_prev_reg;
    logic                        shock_level_reg;

    // ------------------------------------------------------------------
    // Timer connections
    // ------------------------------------------------------------------
    logic [15:0]                 timer_count;
    logic                        timer_zero_event;
    logic                        timer_stop;
    irq_ctl_pkg::timer_cfg_t     timer_cfg;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire hit_mask    = (i_req.addr == irq_ctl_pkg::OFFS_ENABLE_MASK);
    wire hit_pending = (i_req.addr == irq_ctl_pkg::OFFS_PENDING_FLAGS);
    wire hit_tctl    = (i_req.addr == irq_ctl_pkg::OFFS_TIMER_CONTROL);
    wire hit_tinit   = (i_req.addr == irq_ctl_pkg::OFFS_TIMER_INITIAL);
    wire hit_tcount  = (i_req.addr == irq_ctl_pkg::OFFS_TIMER_CURRENT);

    wire wr_mask     = i_req.wr && hit_mask;
    wire wr_pending  = i_req.wr && hit_pending;
    wire wr_tctl     = i_req.wr && hit_tctl;
    wire wr_tinit    = i_req.wr && hit_tinit;

    // Merge a write into a stored value, keeping bits that are not writable
    function automatic logic [15:0] merge_write(input logic [15:0] old_val,
                                                input logic [15:0] new_val,
                                                input logic [15:0] writable);
        merge_write = (old_val & ~writable) | (new_val & writable);
    endfunction

    // ------------------------------------------------------------------
    // Source event detection
    // ------------------------------------------------------------------
    // Peripheral requests are levels; only their rising edge counts, so a
    // source that stays high does not refill a bit software just cleared.
    wire [8:0] src_rise  = i_src & ~src_prev_reg;

    // The external pin is idle high and requests on its falling edge
    wire       ext_fall  = ext_pin_prev_reg && !i_external_irq_pin;

    logic [15:0] event_bits;
    always_comb begin
        event_bits                                      = 16'h0000;
        event_bits[irq_ctl_pkg::BIT_SERIAL_TX]          = src_rise[0];
        event_bits[irq_ctl_pkg::BIT_SERIAL_RX]          = src_rise[1];
        event_bits[irq_ctl_pkg::BIT_TIMER_ZERO]         = timer_zero_event;
        event_bits[irq_ctl_pkg::BIT_COMMAND_DONE]       = src_rise[2];
        event_bits[irq_ctl_pkg::BIT_EXTERNAL]           = ext_fall;
        event_bits[irq_ctl_pkg::BIT_SPINDLE]            = src_rise[3];
        event_bits[irq_ctl_pkg::BIT_SEARCH_WINDOW]      = src_rise[5];
        event_bits[irq_ctl_pkg::BIT_ACQUISITION]        = src_rise[6];
        event_bits[irq_ctl_pkg::BIT_BURST]              = src_rise[7];
        event_bits[irq_ctl_pkg::BIT_SETPOINT_ON]        = src_rise[8];
    end

    // ------------------------------------------------------------------
    // Mask register
    // ------------------------------------------------------------------
    // Shock bit and reserved bits are held at zero by the writable mask
    assign enable_mask_next = wr_mask ?
        merge_write(enable_mask_reg, i_req.wdata, irq_ctl_pkg::WRITABLE_BITS) :
        enable_mask_reg;

    // ------------------------------------------------------------------
    // Pending register
    // ------------------------------------------------------------------
    // Clear only where a one is written; zeros leave bits alone. Events are
    // ORed in after the clear so a simultaneous event is never lost. The
    // mask takes no part here, so masked sources still leave a record.
    wire [15:0] clear_bits = wr_pending ?
                             (i_req.wdata & irq_ctl_pkg::WRITABLE_BITS) :
                             16'h0000;

    assign pending_flags_next =
        ((pending_flags_reg & ~clear_bits) | event_bits)
        & irq_ctl_pkg::WRITABLE_BITS;

    // Shock is a live level, not a latched record
    wire [15:0] pending_view = pending_flags_reg
        | (16'(shock_level_reg) << irq_ctl_pkg::BIT_SHOCK);

    // ------------------------------------------------------------------
    // Timer registers
    // ------------------------------------------------------------------
    wire       run_written = wr_tctl && i_req.wdata[irq_ctl_pkg::TCTL_RUN];
    wire       timer_start = run_written && !timer_ctl_reg[irq_ctl_pkg::TCTL_RUN];
    logic [15:0] tctl_written;

    assign tctl_written = wr_tctl ?
        merge_write(timer_ctl_reg, i_req.wdata, irq_ctl_pkg::TCTL_WRITABLE) :
        timer_ctl_reg;

    // A software write wins over the single-shot self stop in the same cycle
    assign timer_ctl_next = (timer_stop && !wr_tctl) ?
        (timer_ctl_reg & ~(16'h0001 << irq_ctl_pkg::TCTL_RUN)) :
        tctl_written;

    assign timer_init_next = wr_tinit ? i_req.wdata : timer_init_reg;

    assign timer_cfg.periodic = timer_ctl_reg[irq_ctl_pkg::TCTL_PERIODIC];
    assign timer_cfg.prescale = timer_ctl_reg[irq_ctl_pkg::TCTL_PRESCALE_MSB:0];

    event_timer #(
        .COUNT_W      (16),
        .PRESCALE_W   (7)
    ) u_timer (
        .i_sys_clk    (i_sys_clk),
        .i_rst_b      (i_rst_b),
        .i_cfg        (timer_cfg),
        .i_run        (timer_ctl_reg[irq_ctl_pkg::TCTL_RUN]),
        .i_start      (timer_start),
        .i_initial    (timer_init_reg),
        .o_count      (timer_count),
        .o_zero_event (timer_zero_event),
        .o_stop       (timer_stop)
    );

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Unmapped addresses read zero
    always_comb begin
        if (hit_mask) begin
            rd_data_next = enable_mask_reg;
        end else if (hit_pending) begin
            rd_data_next = pending_view;
        end else if (hit_tctl) begin
            rd_data_next = timer_ctl_reg;
        end else if (hit_tinit) begin
            rd_data_next = timer_init_reg;
        end else if (hit_tcount) begin
            rd_data_next = timer_count;
        end else begin
            rd_data_next = 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt lines
    // ------------------------------------------------------------------
    // Priority between the two lines is resolved inside the core; this block
    // only keeps them separate so the servo line is never delayed by others.
    wire [15:0] enabled_pending = pending_flags_reg & enable_mask_reg;
    wire        servo_next   = |(enabled_pending & irq_ctl_pkg::SERVO_SECTOR_BITS);
    // Shock has no writable enable, so it reaches the general line directly
    wire        general_next = |(enabled_pending & irq_ctl_pkg::GENERAL_BITS)
                               | shock_level_reg;

    // ------------------------------------------------------------------
    // State update
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            enable_mask_reg   <= irq_ctl_pkg::MASK_RESET;
            pending_flags_reg <= irq_ctl_pkg::PENDING_RESET;
            timer_ctl_reg     <= irq_ctl_pkg::TCTL_RESET;
            timer_init_reg    <= irq_ctl_pkg::TINIT_RESET;
        end else begin
            enable_mask_reg   <= enable_mask_next;
            pending_flags_reg <= pending_flags_next;
            timer_ctl_reg     <= timer_ctl_next;
            timer_init_reg    <= timer_init_next;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            src_prev_reg     <= '0;
            ext_pin_prev_reg <= irq_ctl_pkg::EXT_PIN_IDLE;
            shock_level_reg  <= 1'b0;
        end else begin
            src_prev_reg     <= i_src;
            ext_pin_prev_reg <= i_external_irq_pin;
            shock_level_reg  <= i_src.shock;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rd_data               <= 16'h0000;
            o_servo_sector_irq_line <= 1'b0;
            o_general_irq_line      <= 1'b0;
        end else begin
            o_rd_data               <= i_req.rd ? rd_data_next : 16'h0000;
            o_servo_sector_irq_line <= servo_next;
            o_general_irq_line      <= general_next;
        end
    end

endmodule

// ### sim/irq_ctl_checker.sv
// Port checker for the interrupt control block
`timescale 1ns/1ns
module irq_ctl_checker (
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_rst_b,
    input  wire irq_ctl_pkg::reg_req_t    i_req,
    input  wire irq_ctl_pkg::src_levels_t i_src,
    input  wire logic                     i_external_irq_pin,
    input  wire logic [15:0]              o_rd_data,
    input  wire logic                     o_servo_sector_irq_line,
    input  wire logic                     o_general_irq_line
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);

    // ---------------------------------------------
    // Shadow of the enable mask as software wrote it
    // ---------------------------------------------
    logic [15:0] mask_reg;
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            mask_reg <= 16'h0000;
        else if (i_req.wr && i_req.addr == 8'h00)
            mask_reg <= i_req.wdata & 16'h0f3f;
    end

    sequence search_rise;
        !i_src.search_window_open ##1 i_src.search_window_open;
    endsequence
    sequence ext_fall;
        i_external_irq_pin ##1 !i_external_irq_pin;
    endsequence

    chk_reserved_zero: assert property (o_rd_data[15:12] == 4'h0 && !o_rd_data[6])
        else $error("reserved read bits not zero");
    chk_read_idle: assert property (!$past(i_req.rd) |-> o_rd_data == 16'h0000)
        else $error("read data outside answer cycle");
    chk_mask_readback: assert property ($past(i_req.rd && i_req.addr == 8'h00)
        |-> o_rd_data == $past(mask_reg)) else $error("mask readback wrong");
    chk_unmapped_zero: assert property ($past(i_req.rd && i_req.addr > 8'h04)
        |-> o_rd_data == 16'h0000) else $error("unmapped read not zero");
    chk_servo_event: assert property (search_rise ##0 mask_reg[8]
        |-> ##2 o_servo_sector_irq_line) else $error("servo line missed event");
    chk_ext_event: assert property (ext_fall ##0 mask_reg[4]
        |-> ##2 o_general_irq_line) else $error("general line missed pin fall");
    chk_servo_masked: assert property ((mask_reg[11:8] == 4'h0) [*3]
        |-> !o_servo_sector_irq_line) else $error("servo line high while masked");
    chk_general_cause: assert property ($rose(o_general_irq_line)
        |-> (|$past(mask_reg[5:0])) || $past(i_src.shock) || $past(i_src.shock, 2))
        else $error("general line rose without enabled cause");
    chk_shock_level: assert property (i_src.shock [*3] |-> o_general_irq_line)
        else $error("shock level not on general line");
    chk_shock_mirror: assert property ($past(i_req.rd && i_req.addr == 8'h01)
        && $past(i_src.shock, 2) && $past(i_src.shock) |-> o_rd_data[7])
        else $error("pending shock bit not set");
endmodule

bind dsp_interrupt_control_block irq_ctl_checker chk_u (
    .i_sys_clk               (i_sys_clk),
    .i_rst_b                 (i_rst_b),
    .i_req                   (i_req),
    .i_src                   (i_src),
    .i_external_irq_pin      (i_external_irq_pin),
    .o_rd_data               (o_rd_data),
    .o_servo_sector_irq_line (o_servo_sector_irq_line),
    .o_general_irq_line      (o_general_irq_line)
);

// ### sim/irq_src_model.sv
// Model of the peripheral event sources and the external interrupt pin
`timescale 1ns/1ns
module irq_src_model (
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_rst_b,
    input  wire logic [9:0]               i_fire,
    input  wire logic                     i_shock,
    output irq_ctl_pkg::src_levels_t      o_src,
    output logic                          o_ext_pin
);
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_src     <= '0;
            o_ext_pin <= 1'b1;
        end else begin
            // Peripherals pulse high per event; shock is a held level
            o_src       <= (i_fire[8:0] & 9'h1ef) | {4'h0, i_shock, 4'h0};
            // Pin idles high on its pull-up and dips low for an event
            o_ext_pin   <= ~i_fire[9];
        end
    end
endmodule

// ### sim/testbench.sv
// Self-checking testbench for the interrupt control block
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module testbench;
    logic                     i_sys_clk = 1'b0;
    logic                     i_rst_b = 1'b0;
    irq_ctl_pkg::reg_req_t    req = '0;
    irq_ctl_pkg::src_levels_t src;
    logic                     ext_pin;
    logic [9:0]               fire = '0;
    logic                     shock = 1'b0;
    logic [15:0]              rd_data;
    logic                     servo_line;
    logic                     general_line;
    logic [15:0]              mask;
    logic [15:0]              bit_v;
    logic [15:0]              got;
    int                       n_mismatch = 0;
    int                       num_checks = 0;
    int                       seed = 32'hfae1;
    int                       pos [10] = '{0, 1, 3, 5, 7, 8, 9, 10, 11, 4};
    int                       k;
    int                       n;

    always #5 i_sys_clk = ~i_sys_clk;

    irq_src_model src_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_fire(fire),
        .i_shock(shock), .o_src(src), .o_ext_pin(ext_pin));

    dsp_interrupt_control_block dut_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
        .i_req(req), .i_src(src), .i_external_irq_pin(ext_pin), .o_rd_data(rd_data),
        .o_servo_sector_irq_line(servo_line), .o_general_irq_line(general_line));

    // ---------------------------------------------
    // Bus tasks and expectations
    // ---------------------------------------------
    function automatic logic exp_line(input logic [15:0] p, m, g);
        return |(p & m & g);
    endfunction

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge i_sys_clk);
        req.wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_sys_clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge i_sys_clk);
        req.rd   <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic pulse(input logic [9:0] f);
        @(posedge i_sys_clk);
        fire <= f;
        @(posedge i_sys_clk);
        fire <= '0;
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        rd_reg(8'h00, got);
        `CHK(got, 16'h0000);
        rd_reg(8'h01, got);
        `CHK(got, 16'h0000);
        wr_reg(8'h00, 16'hffff);
        rd_reg(8'h00, got);
        `CHK(got, 16'h0f3f);
        rd_reg(8'h20, got);
        `CHK(got, 16'h0000);
        // Random masks against every pulsed source except shock and timer, masked ones included
        for (int i = 0; i < 40; i++) begin
            mask = 16'($random(seed)) & 16'h0f3f;
            k = (i < 10) ? i : int'($unsigned($random(seed)) % 10);
            if (k == 4)
                k = 9;
            bit_v = 16'h0001 << pos[k];
            wr_reg(8'h00, mask);
            pulse(10'h001 << k);
            repeat (3) @(posedge i_sys_clk);
            #1;
            `CHK(servo_line, exp_line(bit_v, mask, 16'h0f00));
            `CHK(general_line, exp_line(bit_v, mask, 16'h003f));
            rd_reg(8'h01, got);
            `CHK(got, bit_v);
            wr_reg(8'h01, ~bit_v);
            rd_reg(8'h01, got);
            `CHK(got, bit_v);
            wr_reg(8'h01, bit_v);
            rd_reg(8'h01, got);
            `CHK(got, 16'h0000);
            `CHK(servo_line | general_line, 1'b0);
        end
        // Event lands on the same edge as its clear: set must win
        pulse(10'h020);
        repeat (3) @(posedge i_sys_clk);
        @(posedge i_sys_clk);
        fire <= 10'h020;
        wr_reg(8'h01, 16'h0100);
        fire <= '0;
        rd_reg(8'h01, got);
        `CHK(got, 16'h0100);
        wr_reg(8'h01, 16'h0f3f);
        wr_reg(8'h00, 16'h0000);
        shock <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        #1;
        `CHK(general_line, 1'b1);
        rd_reg(8'h01, got);
        `CHK(got, 16'h0080);
        shock <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        #1;
        `CHK(general_line, 1'b0);
        // Single-shot timer run from a small initial count
        wr_reg(8'h00, 16'h0004);
        wr_reg(8'h03, 16'h0003);
        wr_reg(8'h02, 16'h0080);
        got = '0;
        n = 0;
        while (got !== 16'h0004 && n < 40) begin
            rd_reg(8'h01, got);
            n++;
        end
        `CHK(got, 16'h0004);
        `CHK(general_line, 1'b1);
        rd_reg(8'h02, got);
        `CHK(got, 16'h0000);
        rd_reg(8'h04, got);
        `CHK(got, 16'h0000);
        rd_reg(8'h03, got);
        `CHK(got, 16'h0003);
        wr_reg(8'h01, 16'h0004);
        // Periodic run: the event comes back after each clear
        wr_reg(8'h03, 16'h0001);
        wr_reg(8'h02, 16'h0181);
        for (int r = 0; r < 2; r++) begin
            got = '0;
            n = 0;
            while (got !== 16'h0004 && n < 40) begin
                rd_reg(8'h01, got);
                n++;
            end
            `CHK(got, 16'h0004);
            wr_reg(8'h01, 16'h0004);
        end
        wr_reg(8'h02, 16'h0000);
        wr_reg(8'h01, 16'h0004);
        rd_reg(8'h01, got);
        `CHK(got, 16'h0000);
        print_verdict();
    end

    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
endmodule
